// >>> hw/pme_top.sv
// Purpose: address paging, program/vector select and port g pin routing
// Assumes: cpu address and select inputs come from logic on MCLK
// Notes:   all outputs are registered; address, select and port g outputs land one cycle after the cpu address
`timescale 1ns/1ps

module pme_top (
  // clock and reset
  input  wire logic                     MCLK,
  input  wire logic                     RST_N,
  // avalon-mm register slave
  input  wire logic [pme_pkg::ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                     AVS_READ,
  input  wire logic                     AVS_WRITE,
  input  wire logic [31:0]              AVS_WRITEDATA,
  input  wire logic [3:0]               AVS_BYTEENABLE,
  output logic      [31:0]              AVS_READDATA,
  output logic                          AVS_WAITREQUEST,
  // cpu side
  input  wire logic [15:0]              CPU_ADDR,
  input  wire logic [4:0]               GP_SELECT_N,
  input  wire logic [7:0]               GPIO_OUT,
  input  wire logic [7:0]               GPIO_OE,
  // external bus side
  output logic      [15:0]              EXT_ADDR,
  output logic      [1:0]               EXTENDED_ADDR_LINES,
  output logic                          PROGRAM_SELECT_N,
  output logic                          VECTOR_SELECT_N,
  output logic      [7:0]               PORTG_OUT,
  output logic      [7:0]               PORTG_OE,
  output logic                          PORTG_PULLUP_EN
);

  // reset synchroniser
  logic rst_meta_n;
  logic rst_n;

  // registers
  logic [7:0] vec_start;
  logic [7:0] window_start_reg;
  logic [7:0] window_end_reg;
  logic [7:0] expansion_offset_high;
  logic [7:0] expansion_offset_low;
  logic [7:0] port_g_function_enable;
  pme_pkg::pme_bus_t bus_state;

  // release reset through two flops, assert asynchronously
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_meta_n <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n      <= rst_meta_n;
    end
  end

  // bus decode
  wire [6:0] reg_index   = AVS_ADDRESS[pme_pkg::ADDR_W-1:2];
  wire       bus_req     = AVS_READ | AVS_WRITE;
  wire       bus_commit  = (bus_state == pme_pkg::BUS_DONE);
  wire       wr_en       = AVS_WRITE & bus_commit & AVS_BYTEENABLE[0];
  wire       sel_vec     = (reg_index == pme_pkg::IDX_VEC_START);
  wire       sel_wstart  = (reg_index == pme_pkg::IDX_WIN_START);
  wire       sel_wend    = (reg_index == pme_pkg::IDX_WIN_END);
  wire       sel_ofs_hi  = (reg_index == pme_pkg::IDX_OFS_HIGH);
  wire       sel_ofs_lo  = (reg_index == pme_pkg::IDX_OFS_LOW);
  wire       sel_portg   = (reg_index == pme_pkg::IDX_PORTG_EN);
  wire [7:0] wbyte       = AVS_WRITEDATA[7:0];

  // read mux; unmapped indices and unused high bits read zero
  wire [7:0] rd_byte =
    sel_vec    ? vec_start :
    sel_wstart ? window_start_reg :
    sel_wend   ? window_end_reg :
    sel_ofs_hi ? expansion_offset_high :
    sel_ofs_lo ? expansion_offset_low :
    sel_portg  ? port_g_function_enable : 8'h00;

  // handshake: waitrequest idles high, drops for exactly one cycle
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      bus_state       <= pme_pkg::BUS_IDLE;
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= 32'h0000_0000;
    end else begin
      case (bus_state)
        pme_pkg::BUS_IDLE: begin
          if (bus_req) begin
            bus_state       <= pme_pkg::BUS_DONE;
            AVS_WAITREQUEST <= 1'b0;
            AVS_READDATA    <= {24'h00_0000, rd_byte};
          end
        end
        pme_pkg::BUS_DONE: begin
          bus_state       <= pme_pkg::BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
        default: begin
          bus_state       <= pme_pkg::BUS_IDLE;
          AVS_WAITREQUEST <= 1'b1;
        end
      endcase
    end
  end

  // register writes take effect at the edge that ends the request
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      vec_start              <= pme_pkg::RST_VEC_START;
      window_start_reg       <= pme_pkg::RST_WIN_START;
      window_end_reg         <= pme_pkg::RST_WIN_END;
      expansion_offset_high  <= pme_pkg::RST_OFS_HIGH;
      expansion_offset_low   <= pme_pkg::RST_OFS_LOW;
      port_g_function_enable <= pme_pkg::RST_PORTG_EN;
    end else if (wr_en) begin
      if (sel_vec)
        vec_start <= {wbyte[7:2], 2'b00};
      if (sel_wstart)
        window_start_reg <= wbyte;
      if (sel_wend)
        window_end_reg <= {wbyte[7:2], 2'b00};
      if (sel_ofs_hi)
        expansion_offset_high <= {6'h00, wbyte[1:0]};
      if (sel_ofs_lo)
        expansion_offset_low <= {wbyte[7:2], 2'b00};
      if (sel_portg)
        port_g_function_enable <= wbyte;
    end
  end

  // mode and enables
  pme_pkg::pme_mode_t mode;
  assign mode = pme_pkg::pme_mode_t'(port_g_function_enable[pme_pkg::POS_MODE_LSB +: 2]);
  wire [4:0] gp_select_enables  = port_g_function_enable[pme_pkg::POS_GP_EN_LSB +: 5];
  wire       pin0_select_enable = port_g_function_enable[pme_pkg::POS_PIN0_EN];
  wire       expanding          = (mode != pme_pkg::MODE_NONE);
  wire       xa16_pin           = (mode == pme_pkg::MODE_128K) | (mode == pme_pkg::MODE_256K);
  wire       xa17_pin           = (mode == pme_pkg::MODE_256K);

  // range decode on cpu bits 15:10 only, 1 kbyte granularity
  wire [5:0] cpu_page          = CPU_ADDR[15:pme_pkg::CPU_PAGE_LSB];
  wire [5:0] window_start_bits = window_start_reg[7:pme_pkg::POS_RANGE_LSB];
  wire [5:0] window_end_bits   = window_end_reg[7:pme_pkg::POS_RANGE_LSB];
  wire [5:0] vec_start_bits    = vec_start[7:pme_pkg::POS_RANGE_LSB];
  wire       in_window = (cpu_page >= window_start_bits) & (cpu_page <= window_end_bits);
  wire       in_vector = (cpu_page >= vec_start_bits);

  // vector range outranks the program window
  wire       hit_vector  = expanding & in_vector;
  wire       hit_program = expanding & in_window & ~in_vector;

  // translation: 8-bit sum, carry out of bit 7 is simply lost
  wire [7:0] offset_bits = {expansion_offset_high[1:0], expansion_offset_low[7:2]};
  wire [7:0] page_sum    = {2'b00, cpu_page} + offset_bits;

  // upper six lines: sum in window, raw page otherwise
  wire [5:0] next_upper = hit_program ? page_sum[5:0] : cpu_page;

  // extended lines: sum bits in window, forced high in vector space;
  // only the port g pins drop bits above the active width; EXTENDED_ADDR_LINES carries both
  wire       next_xa16 = hit_vector  ? 1'b1 :
                         hit_program ? page_sum[6] :
                         expansion_offset_high[0];
  wire       next_xa17 = hit_vector  ? 1'b1 :
                         hit_program ? page_sum[7] :
                         expansion_offset_high[1];
  wire [1:0] next_xa   = {next_xa17, next_xa16};

  wire       next_prog_n = ~hit_program;
  wire       next_vec_n  = ~hit_vector;
  wire       next_pv_n   = next_prog_n & next_vec_n;

  // port g routing: pin 0 select, pins 2:1 address, pins 7:3 selects
  logic [7:0] next_pg_out;
  logic [7:0] next_pg_oe;
  always_comb begin
    next_pg_out = GPIO_OUT;
    next_pg_oe  = GPIO_OE;
    if (pin0_select_enable) begin
      next_pg_out[0] = next_pv_n;
      next_pg_oe[0]  = 1'b1;
    end
    if (xa16_pin) begin
      next_pg_out[1] = next_xa16;
      next_pg_oe[1]  = 1'b1;
    end
    if (xa17_pin) begin
      next_pg_out[2] = next_xa17;
      next_pg_oe[2]  = 1'b1;
    end
    for (int i = 0; i < 5; i++) begin
      if (gp_select_enables[i]) begin
        next_pg_out[i+3] = GP_SELECT_N[i];
        next_pg_oe[i+3]  = 1'b1;
      end
    end
  end

  // output stage; reset leaves every select and address line high
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      EXT_ADDR            <= 16'hffff;
      EXTENDED_ADDR_LINES <= 2'b11;
      PROGRAM_SELECT_N    <= 1'b1;
      VECTOR_SELECT_N     <= 1'b1;
      PORTG_OUT           <= 8'hff;
      PORTG_OE            <= 8'h00;
      PORTG_PULLUP_EN     <= 1'b1;
    end else begin
      EXT_ADDR            <= {next_upper, CPU_ADDR[9:0]};
      EXTENDED_ADDR_LINES <= next_xa;
      PROGRAM_SELECT_N    <= next_prog_n;
      VECTOR_SELECT_N     <= next_vec_n;
      PORTG_OUT           <= next_pg_out;
      PORTG_OE            <= next_pg_oe;
      PORTG_PULLUP_EN     <= 1'b1;
    end
  end

endmodule

// >>> hw/pme_pkg.sv
// Purpose: shared constants for the paged memory expansion block
// Assumes: Avalon-MM slave with 32-bit data, one register per word
// Notes:   byte address of a register is four times its index
package pme_pkg;

  // register indices; byte address = index * 4
  localparam logic [6:0] IDX_VEC_START  = 7'h40;
  localparam logic [6:0] IDX_WIN_START  = 7'h42;
  localparam logic [6:0] IDX_WIN_END    = 7'h43;
  localparam logic [6:0] IDX_OFS_HIGH   = 7'h44;
  localparam logic [6:0] IDX_OFS_LOW    = 7'h45;
  localparam logic [6:0] IDX_PORTG_EN   = 7'h71;
  localparam int         ADDR_W         = 9;

  // values after reset
  localparam logic [7:0] RST_VEC_START  = 8'h00;
  localparam logic [7:0] RST_WIN_START  = 8'h01;
  localparam logic [7:0] RST_WIN_END    = 8'h00;
  localparam logic [7:0] RST_OFS_HIGH   = 8'h00;
  localparam logic [7:0] RST_OFS_LOW    = 8'h00;
  localparam logic [7:0] RST_PORTG_EN   = 8'h00;

  // field positions
  localparam int         POS_RANGE_LSB  = 2;
  localparam int         POS_MODE_LSB   = 1;
  localparam int         POS_PIN0_EN    = 0;
  localparam int         POS_GP_EN_LSB  = 3;
  localparam int         CPU_PAGE_LSB   = 10;

  // expansion modes held in the port g enable register
  typedef enum logic [1:0] {
    MODE_NONE  = 2'b00,
    MODE_64K   = 2'b01,
    MODE_128K  = 2'b10,
    MODE_256K  = 2'b11
  } pme_mode_t;

  // bus slave handshake states
  typedef enum logic {
    BUS_IDLE,
    BUS_DONE
  } pme_bus_t;

endpackage

// >>> verif/pme_asserts.sv
// Purpose: port-level checks for the paged memory expansion block
// Assumes: outputs follow inputs by one MCLK edge
// Notes:   live masks the two-flop reset release
`timescale 1ns/1ps
module pme_asserts (
  // watched ports
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic        AVS_WAITREQUEST,
  input wire logic [15:0] CPU_ADDR,
  input wire logic [4:0]  GP_SELECT_N,
  input wire logic [7:0]  GPIO_OE,
  input wire logic [15:0] EXT_ADDR,
  input wire logic [1:0]  EXTENDED_ADDR_LINES,
  input wire logic        PROGRAM_SELECT_N,
  input wire logic        VECTOR_SELECT_N,
  input wire logic [7:0]  PORTG_OUT,
  input wire logic [7:0]  PORTG_OE
);
  logic [2:0] up;
  wire        live = up[2];
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  // internal reset lags by two flops, so trust outputs from the third edge
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) up <= 3'h0;
    else up <= {up[1:0], 1'b1};
  end
  a_low_pass:
    assert property (live |-> EXT_ADDR[9:0] == $past(CPU_ADDR[9:0])) else $error("low lines altered");
  a_outside_pass:
    assert property (live && PROGRAM_SELECT_N |-> EXT_ADDR[15:10] == $past(CPU_ADDR[15:10])) else $error("page altered");
  a_vector_top:
    assert property (live && !VECTOR_SELECT_N |-> EXTENDED_ADDR_LINES == 2'h3 && EXT_ADDR == $past(CPU_ADDR))
    else $error("vector access not at top");
  a_select_excl:
    assert property (PROGRAM_SELECT_N || VECTOR_SELECT_N) else $error("both selects low");
  a_pin0_route:
    assert property (live && PORTG_OE[0] && !$past(GPIO_OE[0]) |-> PORTG_OUT[0] == (PROGRAM_SELECT_N & VECTOR_SELECT_N))
    else $error("pin0 not select");
  a_gp_route:
    assert property (live && PORTG_OE[7] && !$past(GPIO_OE[7]) |-> PORTG_OUT[7] == $past(GP_SELECT_N[4]))
    else $error("pin7 not select");
  a_xa_pins:
    assert property (live && PORTG_OE[2] && !$past(GPIO_OE[2]) |-> PORTG_OUT[2:1] == EXTENDED_ADDR_LINES && PORTG_OE[1])
    else $error("pins 2,1 not address");
  a_bus_answer:
    assert property (live && (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
    else $error("bus answer late");
endmodule
bind pme_top pme_asserts i_chk (.MCLK(MCLK), .RST_N(RST_N), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CPU_ADDR(CPU_ADDR), .GP_SELECT_N(GP_SELECT_N), .GPIO_OE(GPIO_OE),
  .EXT_ADDR(EXT_ADDR), .EXTENDED_ADDR_LINES(EXTENDED_ADDR_LINES), .PROGRAM_SELECT_N(PROGRAM_SELECT_N),
  .VECTOR_SELECT_N(VECTOR_SELECT_N), .PORTG_OUT(PORTG_OUT), .PORTG_OE(PORTG_OE));

// >>> verif/pme_ext_mem.sv
// Purpose: external memory on the expanded bus, 18-bit physical address
// Assumes: selects are active low and sampled on the clock
// Notes:   no pull on the data bus, so an idle cycle flips the last value
`timescale 1ns/1ps
module pme_ext_mem (
  // bus side
  input  wire logic        clk,
  input  wire logic [15:0] addr,
  input  wire logic [1:0]  xa,
  input  wire logic        prog_n,
  input  wire logic        vec_n,
  // data back to the cpu
  output logic      [7:0]  data
);
  // selected: data hashed from the physical page and low byte
  always_ff @(posedge clk) begin
    if (!prog_n || !vec_n) data <= addr[7:0] ^ {xa, addr[15:10]};
    else data <= ~data;
  end
endmodule

// >>> verif/tb_pme_top.sv
// Purpose: self-checking bench for the paged memory expansion block
// Assumes: one-cycle address path, one-cycle register answer
// Notes:   expected values come from register shadows held here
`timescale 1ns/1ps
module tb_pme_top;
  logic        MCLK = 0, RST_N = 0, AVS_READ = 0, AVS_WRITE = 0, WAITR, PSN, VSN, PUP;
  logic [8:0]  AVS_ADDRESS = 9'h000;
  logic [31:0] WDATA = 32'h0, RDATA;
  logic [3:0]  BE = 4'hf;
  logic [15:0] CPU_ADDR = 16'h0, EXT_ADDR;
  logic [4:0]  GSN = 5'h1f;
  logic [7:0]  GOUT = 8'h0, GOE = 8'h0, PG_OUT, PG_OE, mem_data;
  logic [1:0]  XA, mode = 2'h0, oh = 2'h0;
  logic [5:0]  ws = 6'h0, we = 6'h0, vs = 6'h0, ol = 6'h0;
  logic [35:0] q[$], last = 36'h0;
  logic [4:0]  ge = 5'h0;
  logic        p0 = 1'b0, last_v = 1'b0;
  logic [7:0]  ofs;
  logic [7:0]  rq[$];
  int          num_errors = 0, num_checks = 0, cyc_n = 0, old = 0, seed = 32'h99da7164;
  pme_top i_dut (.MCLK(MCLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(WDATA), .AVS_BYTEENABLE(BE), .AVS_READDATA(RDATA), .AVS_WAITREQUEST(WAITR), .CPU_ADDR(CPU_ADDR),
    .GP_SELECT_N(GSN), .GPIO_OUT(GOUT), .GPIO_OE(GOE), .EXT_ADDR(EXT_ADDR), .EXTENDED_ADDR_LINES(XA),
    .PROGRAM_SELECT_N(PSN), .VECTOR_SELECT_N(VSN), .PORTG_OUT(PG_OUT), .PORTG_OE(PG_OE), .PORTG_PULLUP_EN(PUP));
  pme_ext_mem i_mem (.clk(MCLK), .addr(EXT_ADDR), .xa(XA), .prog_n(PSN), .vec_n(VSN), .data(mem_data));
  always #5 MCLK = ~MCLK;
  task automatic chk(input logic ok);
    num_checks++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("[FAIL] %0t mismatch", $time);
    end
  endtask
  // expected pins, page, extended lines and selects for one cpu address
  function automatic logic [35:0] want(input logic [15:0] a, input logic [4:0] g, input logic [7:0] o, e);
    logic [7:0] sum;
    logic       vh, ph;
    logic [1:0] x;
    vh = (mode != 2'h0) && (a[15:10] >= vs);
    ph = (mode != 2'h0) && !vh && (a[15:10] >= ws) && (a[15:10] <= we);
    sum = {2'h0, a[15:10]} + {oh, ol};
    x = vh ? 2'h3 : (ph ? sum[7:6] : oh);
    if (p0) begin
      o[0] = !ph && !vh;
      e[0] = 1'b1;
    end
    if (mode[1]) begin
      o[1] = x[0];
      e[1] = 1'b1;
    end
    if (mode == 2'h3) begin
      o[2] = x[1];
      e[2] = 1'b1;
    end
    for (int k = 0; k < 5; k++) begin
      if (ge[k]) begin
        o[k+3] = g[k];
        e[k+3] = 1'b1;
      end
    end
    return {o, e, ph ? sum[5:0] : a[15:10], a[9:0], x, !ph, !vh};
  endfunction
  // one request held until waitrequest is seen low
  task automatic bus(input logic rd, input logic [6:0] idx, input logic [7:0] d, input logic [3:0] be);
    @(posedge MCLK);
    AVS_ADDRESS <= {idx, 2'b00};
    AVS_READ <= rd;
    AVS_WRITE <= !rd;
    WDATA <= {24'h0, d};
    BE <= be;
    if (rd) rq.push_back(d);
    do @(posedge MCLK); while (WAITR !== 1'b0);
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask
  task automatic cpu(input logic [15:0] a);
    logic [4:0] g;
    logic [7:0] o, e;
    @(posedge MCLK);
    g = 5'($random(seed));
    o = 8'($random(seed));
    e = 8'($random(seed));
    CPU_ADDR <= a;
    GSN <= g;
    GOUT <= o;
    GOE <= e;
    q.push_back(want(a, g, o, e));
  endtask
  // read data is taken at the edge that ends the wait
  always @(posedge MCLK) begin
    if (AVS_READ && WAITR === 1'b0 && rq.size() > 0) chk(RDATA === {24'h0, rq.pop_front()});
  end
  // address results land one edge after the cpu address
  // the memory model answers one edge later still, from the expected physical page
  always @(negedge MCLK) begin
    if (last_v && !(last[1] && last[0])) chk(mem_data === (last[11:4] ^ {last[3:2], last[19:14]}));
    last_v = 1'b0;
    if (old > 0) begin
      last = q.pop_front();
      last_v = 1'b1;
      chk({PG_OUT, PG_OE, EXT_ADDR, XA, PSN, VSN} === last);
    end
    old = q.size();
  end
  always @(posedge MCLK) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      num_errors++;
      stop_test();
    end
  end
  initial begin
    repeat (8) @(posedge MCLK);
    chk(PG_OUT === 8'hff && PG_OE === 8'h00 && PUP === 1'b1 && {XA, PSN, VSN, WAITR} === 5'h1f);
    RST_N <= 1'b1;
    repeat (3) @(posedge MCLK);
    bus(1, 7'h44, 8'h00, 4'hf);
    bus(1, 7'h71, 8'h00, 4'hf);
    bus(1, 7'h50, 8'h00, 4'hf);
    for (int i = 0; i < 64; i++) cpu({i[5:0], 10'($random(seed))});
    bus(0, 7'h44, 8'hff, 4'he);
    bus(1, 7'h44, 8'h00, 4'hf);
    // each expanding mode, with a page scan across all window and vector edges
    for (int m = 1; m < 4; m++) begin
      mode = m[1:0];
      ws = 6'h18 + 6'(m);
      we = 6'h20 + 6'(m);
      vs = 6'h34;
      ofs = 8'($random(seed)) - {2'h0, ws};
      oh = ofs[7:6];
      ol = ofs[5:0];
      ge = {1'b1, 4'($random(seed))};
      p0 = m[0];
      bus(0, 7'h40, {vs, 2'h0}, 4'hf);
      bus(0, 7'h42, {ws, 2'h1}, 4'hf);
      bus(0, 7'h43, {we, 2'h0}, 4'hf);
      bus(0, 7'h44, {6'h3f, oh}, 4'hf);
      bus(0, 7'h45, {ol, 2'h0}, 4'hf);
      bus(0, 7'h71, {ge, mode, p0}, 4'hf);
      bus(1, 7'h44, {6'h0, oh}, 4'hf);
      bus(1, 7'h71, {ge, mode, p0}, 4'hf);
      for (int i = 0; i < 64; i++) cpu({i[5:0], 10'($random(seed))});
    end
    repeat (3) @(posedge MCLK);
    chk(PUP === 1'b1 && q.size() == 0 && rq.size() == 0);
    stop_test();
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
endmodule
